// ### dv/reset_source_status_bench.sv
// self-checking bench for the reset source block
`timescale 1ns/1ps
module reset_source_status_bench;
    import reset_source_pkg::*;
    logic              clk_sys = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    // 0..8 reset sources, 9 watchdog clear, 10 power save, 11 wake
    logic [11:0]       drv = '0;
    logic              pso = 1'b0;
    logic [1:0]        bcf = 2'h1;
    logic [1:0]        wcf = 2'h0;
    logic              lpc = 1'b0;
    logic              mrst, bor_en, wdt_en, slp, idl, ret, stby, wdone;
    logic [15:0]       exp_q[$];
    logic [15:0]       acc;
    logic              rd_pend = 1'b0;
    logic [31:0]       seed = 32'hbe65250a;
    int                fail_count = 0;
    int                tests_run = 0;
    int                cyc = 0;
    int                n;
    logic [15:0]       bits [1:8] = '{16'h0080, 16'h0040, 16'h0010, 16'h0002,
                                      16'h0200, 16'h8000, 16'h4000, 16'h4000};

    reset_source_status i_dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .power_on_event(drv[0]), .external_clear_pin(drv[1]), .reset_instruction(drv[2]),
        .watchdog_timeout(drv[3]), .brownout_detect(drv[4]), .config_mismatch(drv[5]),
        .trap_conflict(drv[6]), .illegal_opcode(drv[7]), .uninit_wreg_reset(drv[8]),
        .watchdog_clear_instruction(drv[9]), .power_save_instruction(drv[10]),
        .power_save_operand(pso), .wake_event(drv[11]), .brownout_config_field(bcf),
        .low_power_config_bit(lpc), .watchdog_config_field(wcf),
        .master_reset_signal(mrst), .brownout_enable(bor_en), .watchdog_enable(wdt_en),
        .core_sleeping(slp), .core_idling(idl), .retention_active(ret),
        .regulator_standby(stby), .wake_done(wdone));

    always #20 clk_sys = ~clk_sys;

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(string name, logic [15:0] e, logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic test_done();
        $display("mismatches %0d comparisons %0d", fail_count, tests_run);
        if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick(int k);
        repeat (k) @(posedge clk_sys);
    endtask

    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // the expected word is queued; the watcher below compares it
    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
    endtask

    task automatic pulse(int i);
        @(posedge clk_sys);
        drv[i] <= 1'b1;
        @(posedge clk_sys);
        drv[i] <= 1'b0;
    endtask

    task automatic wait_low();
        n = 0;
        while (mrst !== 1'b0 && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk("master_reset_release", 16'h0, 16'(mrst));
    endtask

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (rd_pend)
            chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        rd_pend <= reg_rd;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        tick(2);
        rst <= 1'b0;
        wait_low();
        rd(0, 16'h2003);
        wr(0, 16'h2000);
        acc = 16'h2000;
        // flags pile up across resets; the last pass is power-on
        for (int i = 1; i < 10; i++) begin
            pulse(i % 9);
            acc = (i == 9) ? 16'h2003 : acc | bits[i];
            rd(0, acc);
            chk("master_reset", 16'h1, 16'(mrst));
            wait_low();
        end
        wr(0, 16'h0000);
        pulse(4);
        tick(2);
        chk("master_reset", 16'h0, 16'(mrst));
        rd(0, 16'h0000);
        wcf <= 2'h3;
        tick(2);
        chk("wdt_en", 16'h1, 16'(wdt_en));
        wcf <= 2'h0;
        tick(2);
        chk("wdt_en", 16'h0, 16'(wdt_en));
        chk("bor_en", 16'h0, 16'(bor_en));
        bcf <= 2'h0;
        wr(0, 16'h2000);
        tick(2);
        chk("bor_en", 16'h0, 16'(bor_en));
        bcf <= 2'h1;
        tick(2);
        chk("bor_en", 16'h1, 16'(bor_en));
        for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            wr(0, seed[15:0]);
            rd(0, seed[15:0] & 16'hf3ff);
            chk("master_reset", 16'h0, 16'(mrst));
        end
        wr(0, 16'h0010);
        pulse(9);
        rd(0, 16'h0000);
        for (int f = 1; f >= 0; f--) begin
            wr(0, (f == 1) ? 16'h1100 : 16'h1000);
            pso <= 1'b0;
            // second pass programs the low-power bit, which must block retention
            lpc <= (f == 0);
            pulse(10);
            @(posedge clk_sys);
            chk("sleeping", 16'h1, 16'(slp));
            chk("retention", 16'(f == 1), 16'(ret));
            chk("standby", 16'(f == 0), 16'(stby));
            rd(0, (f == 1) ? 16'h1108 : 16'h1008);
            rd(4'h2, 16'h0001);
            pulse(11);
            n = 0;
            while (wdone !== 1'b1 && n < 400) begin
                @(posedge clk_sys);
                n++;
            end
            chk("wake_done", 16'h1, 16'(wdone));
            chk("slow_wake", 16'(f == 0), 16'(n > 200));
        end
        wr(0, 16'h0010);
        pso <= 1'b1;
        pulse(10);
        @(posedge clk_sys);
        chk("idling", 16'h1, 16'(idl));
        rd(0, 16'h0004);
        pulse(11);
        tick(3);
        chk("idling", 16'h0, 16'(idl));
        // writes off the map are dropped, reads there give zero
        wr(4'h5, 16'hffff);
        rd(0, 16'h0004);
        rd(4'h7, 16'h0000);
        rd(4'h1, 16'h0022);
        tick(3);
        test_done();
    end
endmodule

// ### dv/reset_source_status_sva.sv
// port checker for the reset source block
`timescale 1ns/1ps
module reset_source_status_sva
    import reset_source_pkg::*;
(
    input wire logic              clk_sys,
    input wire logic              rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic              power_on_event,
    input wire logic              external_clear_pin,
    input wire logic              reset_instruction,
    input wire logic              watchdog_timeout,
    input wire logic              brownout_detect,
    input wire logic              config_mismatch,
    input wire logic              trap_conflict,
    input wire logic              illegal_opcode,
    input wire logic              uninit_wreg_reset,
    input wire logic              power_save_instruction,
    input wire logic              power_save_operand,
    input wire logic [1:0]        brownout_config_field,
    input wire logic              low_power_config_bit,
    input wire logic [1:0]        watchdog_config_field,
    input wire logic              master_reset_signal,
    input wire logic              brownout_enable,
    input wire logic              watchdog_enable,
    input wire logic              core_sleeping,
    input wire logic              core_idling,
    input wire logic              retention_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic any_src;
    // brown-out left out: it only counts while enabled
    assign any_src = power_on_event | external_clear_pin | reset_instruction | watchdog_timeout
        | config_mismatch | trap_conflict | illegal_opcode | uninit_wreg_reset;
    sequence s_rd_cause;
        reg_rd && reg_addr == RESET_CAUSE_ADDR;
    endsequence
    sequence s_src_rd(logic s);
        s && !power_on_event ##1 !reg_wr && !power_on_event ##1 s_rd_cause;
    endsequence
    sequence s_psave(logic op);
        power_save_instruction && power_save_operand == op && !master_reset_signal
            && !any_src && !core_sleeping && !core_idling;
    endsequence
    property p_src_reset; any_src |=> master_reset_signal; endproperty
    property p_wr_quiet;
        reg_wr && !any_src && !brownout_detect && !master_reset_signal |=> !master_reset_signal;
    endproperty
    property p_unimpl; s_rd_cause |=> reg_rdata[11:10] == 2'b00; endproperty
    property p_trap_flag; s_src_rd(trap_conflict) |=> reg_rdata[BIT_TRAP]; endproperty
    property p_pin_flag; s_src_rd(external_clear_pin) |=> reg_rdata[BIT_PIN]; endproperty
    property p_wdt_on; watchdog_config_field == WDT_ALWAYS_ON |=> watchdog_enable; endproperty
    property p_bor_off; brownout_config_field == BOR_OFF |=> !brownout_enable; endproperty
    property p_sleep; s_psave(1'b0) |=> core_sleeping && !core_idling; endproperty
    property p_idle; s_psave(1'b1) |=> core_idling && !core_sleeping; endproperty
    property p_retain;
        retention_active |-> core_sleeping && !$past(low_power_config_bit);
    endproperty
    a_src_reset: assert property (p_src_reset) else $error("reset source without master reset");
    a_wr_quiet: assert property (p_wr_quiet) else $error("register write caused a reset");
    a_unimpl: assert property (p_unimpl) else $error("bits 11:10 read nonzero");
    a_trap_flag: assert property (p_trap_flag) else $error("trap flag not set");
    a_pin_flag: assert property (p_pin_flag) else $error("pin flag not set");
    a_wdt_on: assert property (p_wdt_on) else $error("watchdog not forced on");
    a_bor_off: assert property (p_bor_off) else $error("brown-out on while off");
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    a_idle: assert property (p_idle) else $error("idle not entered");
    a_retain: assert property (p_retain) else $error("retention outside sleep");
endmodule

bind reset_source_status reset_source_status_sva i_sva (.clk_sys, .rst, .reg_addr, .reg_wr,
    .reg_rd, .reg_rdata, .power_on_event, .external_clear_pin, .reset_instruction,
    .watchdog_timeout, .brownout_detect, .config_mismatch, .trap_conflict, .illegal_opcode,
    .uninit_wreg_reset, .power_save_instruction, .power_save_operand, .brownout_config_field,
    .low_power_config_bit, .watchdog_config_field, .master_reset_signal, .brownout_enable,
    .watchdog_enable, .core_sleeping, .core_idling, .retention_active);

// ### verilog/cause_if.sv
// bundle between the reset control logic and the cause register store
`timescale 1ns/1ps
interface cause_if;
    logic [15:0] set_bits;
    logic [15:0] clr_bits;
    logic [15:0] wr_data;
    logic        wr_en;
    logic        init;
    logic [15:0] value;

    modport ctrl  (output set_bits, output clr_bits, output wr_data, output wr_en,
                   output init, input value);
    modport store (input set_bits, input clr_bits, input wr_data, input wr_en,
                   input init, output value);
endinterface

// ### verilog/reset_cause_reg.sv
// storage of the reset cause and control register with set-over-clear priority
`timescale 1ns/1ps
module reset_cause_reg
    import reset_source_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    cause_if.store    cif
);

    logic [15:0] next_value;

    always_comb begin
        next_value = cif.wr_en ? cif.wr_data : cif.value;
        next_value = next_value & ~cif.clr_bits;
        // hardware set wins over a same-cycle software or instruction clear
        next_value = next_value | cif.set_bits;
        next_value = next_value & CAUSE_IMPL_MASK;
    end

    always_ff @(posedge clk_sys) begin
        if (rst || cif.init) begin
            cif.value <= CAUSE_POR_VALUE;
        end else begin
            cif.value <= next_value;
        end
    end

endmodule

// ### verilog/reset_source_pkg.sv
// reset cause register layout, reset values and timing counts for the reset source block
// Function
// - master reset is active while any hardware reset source is active
// - each reset source sets its own cause flag in the cause register
// - power-on clears the register except brown-out enable bit 13 and the brown-out and power-on flags, which set
// - software may write any cause flag; writing never causes a reset
// - bit 15 sets on a trap conflict reset; zero after power-on
// - bit 14 sets on illegal opcode, addressing mode or uninitialized pointer use
// - bit 13 enables brown-out, power-on one, effective only when config field is 01
// - bit 12 selects retention regulator in sleep, ignored when low-power bit is one
// - bits 11 and 10 are unimplemented and read zero
// - bit 9 sets on a configuration word mismatch reset
// - bit 8 selects fast wake-up; clear adds regulator delay to sleep wake-up
// - bit 7 sets on an external clear pin reset
// - bit 6 sets when the software reset instruction executes
// - watchdog config field 11 forces watchdog on, ignoring software enable bit
// - bit 4 sets on watchdog time-out, cleared by clear or power-save instruction
// - bit 3 sets on entry to sleep by power-save with operand zero
// - bit 2 sets on entry to idle by power-save with operand one
// - bit 1 sets on brown-out and power-on; bit 0 only on power-on
package reset_source_pkg;

    localparam int          ADDR_W            = 4;
    localparam int          DATA_W            = 16;
    localparam logic [3:0]  RESET_CAUSE_ADDR  = 4'h0;
    localparam logic [3:0]  CONFIG_VIEW_ADDR  = 4'h1;
    localparam logic [3:0]  STATE_VIEW_ADDR   = 4'h2;

    localparam int BIT_TRAP      = 15;
    localparam int BIT_ILLEGAL   = 14;
    localparam int BIT_SBOR_EN   = 13;
    localparam int BIT_RETAIN_EN = 12;
    localparam int BIT_MISMATCH  = 9;
    localparam int BIT_FAST_WAKE = 8;
    localparam int BIT_PIN       = 7;
    localparam int BIT_SW_RESET  = 6;
    localparam int BIT_SWDT_EN   = 5;
    localparam int BIT_WDT_TO    = 4;
    localparam int BIT_SLEEP     = 3;
    localparam int BIT_IDLE      = 2;
    localparam int BIT_BROWNOUT  = 1;
    localparam int BIT_POWER_ON  = 0;

    localparam logic [15:0] CAUSE_POR_VALUE   = 16'h2003;
    localparam logic [15:0] CAUSE_IMPL_MASK   = 16'hf3ff;

    localparam logic [1:0]  BOR_SOFT_CTRL     = 2'h1;
    localparam logic [1:0]  BOR_OFF           = 2'h0;
    localparam logic [1:0]  WDT_ALWAYS_ON     = 2'h3;

    localparam int          CLK_MHZ           = 25;
    localparam int          RESET_HOLD_NS     = 200;
    localparam int          REG_WAKE_DELAY_NS = 10000;
    localparam int          RESET_HOLD_CYC    = (RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int          WAKE_DELAY_CYC    = (REG_WAKE_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int          CNT_W             = 9;

    typedef enum logic [1:0] {
        PWR_RUN       = 2'b00,
        PWR_SLEEP     = 2'b01,
        PWR_IDLE      = 2'b10,
        PWR_WAKE_WAIT = 2'b11
    } power_state_e;

endpackage

// ### verilog/reset_source_status.sv
// reset source merge, cause recording, power-save state and register port
`timescale 1ns/1ps
module reset_source_status
    import reset_source_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    input  wire logic              power_on_event,
    input  wire logic              external_clear_pin,
    input  wire logic              reset_instruction,
    input  wire logic              watchdog_timeout,
    input  wire logic              brownout_detect,
    input  wire logic              config_mismatch,
    input  wire logic              trap_conflict,
    input  wire logic              illegal_opcode,
    input  wire logic              uninit_wreg_reset,
    input  wire logic              watchdog_clear_instruction,
    input  wire logic              power_save_instruction,
    input  wire logic              power_save_operand,
    input  wire logic              wake_event,
    input  wire logic [1:0]        brownout_config_field,
    input  wire logic              low_power_config_bit,
    input  wire logic [1:0]        watchdog_config_field,
    output logic                   master_reset_signal,
    output logic                   brownout_enable,
    output logic                   watchdog_enable,
    output logic                   core_sleeping,
    output logic                   core_idling,
    output logic                   retention_active,
    output logic                   regulator_standby,
    output logic                   wake_done
);

    localparam logic [CNT_W-1:0] HOLD_LOAD = CNT_W'(RESET_HOLD_CYC);
    localparam logic [CNT_W-1:0] WAKE_LOAD = CNT_W'(WAKE_DELAY_CYC);

    cause_if cif ();

    reset_cause_reg u_cause (
        .clk_sys (clk_sys),
        .rst     (rst),
        .cif     (cif)
    );

    logic [15:0]      cause;
    logic             bor_effective;
    logic             wdt_effective;
    logic             any_source;
    logic             bor_reset;
    logic [CNT_W-1:0] hold_cnt;
    logic [CNT_W-1:0] next_hold_cnt;
    logic [CNT_W-1:0] wake_cnt;
    logic             cause_sel;
    logic             psave_sleep;
    logic             psave_idle;
    logic [15:0]      next_set;
    logic [15:0]      next_clr;
    logic [DATA_W-1:0] next_rdata;
    power_state_e     pstate;
    power_state_e     next_pstate;

    assign cause     = cif.value;
    assign cause_sel = (reg_addr == RESET_CAUSE_ADDR);

    // brown-out enable follows soft bit only in soft-control mode
    always_comb begin
        if (brownout_config_field == BOR_SOFT_CTRL) begin
            bor_effective = cause[BIT_SBOR_EN];
        end else if (brownout_config_field == BOR_OFF) begin
            bor_effective = 1'b0;
        end else begin
            bor_effective = 1'b1;
        end
    end

    assign wdt_effective = (watchdog_config_field == WDT_ALWAYS_ON) || cause[BIT_SWDT_EN];

    assign bor_reset = brownout_detect && bor_effective;

    // only hardware sources take part, never register writes
    assign any_source = power_on_event || external_clear_pin || reset_instruction ||
                        watchdog_timeout || bor_reset || config_mismatch ||
                        trap_conflict || illegal_opcode || uninit_wreg_reset;

    assign psave_sleep = power_save_instruction && !power_save_operand && !master_reset_signal;
    assign psave_idle  = power_save_instruction && power_save_operand && !master_reset_signal;

    // each source marks its own flag
    always_comb begin
        next_set = 16'h0000;
        next_set[BIT_TRAP]     = trap_conflict;
        next_set[BIT_ILLEGAL]  = illegal_opcode || uninit_wreg_reset;
        next_set[BIT_MISMATCH] = config_mismatch;
        next_set[BIT_PIN]      = external_clear_pin;
        next_set[BIT_SW_RESET] = reset_instruction;
        next_set[BIT_WDT_TO]   = watchdog_timeout;
        next_set[BIT_SLEEP]    = psave_sleep;
        next_set[BIT_IDLE]     = psave_idle;
        // brown-out flag set by brown-out reset
        next_set[BIT_BROWNOUT] = bor_reset;
    end

    // time-out flag cleared by clear or power-save instruction
    always_comb begin
        next_clr = 16'h0000;
        next_clr[BIT_WDT_TO] = watchdog_clear_instruction || power_save_instruction;
    end

    assign cif.wr_en    = reg_wr && cause_sel;
    assign cif.wr_data  = reg_wdata;
    assign cif.set_bits = next_set;
    assign cif.clr_bits = next_clr;
    // power-on event reinitialises, setting both low flags
    assign cif.init     = power_on_event;

    // hold the master reset a few cycles past the last source so short pulses still reset
    always_comb begin
        if (any_source) begin
            next_hold_cnt = HOLD_LOAD;
        end else if (hold_cnt != '0) begin
            next_hold_cnt = hold_cnt - CNT_W'(1);
        end else begin
            next_hold_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            hold_cnt <= HOLD_LOAD;
        end else begin
            hold_cnt <= next_hold_cnt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            master_reset_signal <= 1'b1;
        end else begin
            master_reset_signal <= any_source || (hold_cnt > CNT_W'(1));
        end
    end

    // power-save state; a master reset always returns the core to run
    always_comb begin
        next_pstate = pstate;
        unique case (pstate)
            PWR_RUN: begin
                if (psave_sleep) begin
                    next_pstate = PWR_SLEEP;
                end else if (psave_idle) begin
                    next_pstate = PWR_IDLE;
                end
            end
            PWR_SLEEP: begin
                if (wake_event) begin
                    // slow wake waits for the regulator
                    next_pstate = cause[BIT_FAST_WAKE] ? PWR_RUN : PWR_WAKE_WAIT;
                end
            end
            PWR_IDLE: begin
                if (wake_event) begin
                    next_pstate = PWR_RUN;
                end
            end
            PWR_WAKE_WAIT: begin
                if (wake_cnt == CNT_W'(1)) begin
                    next_pstate = PWR_RUN;
                end
            end
        endcase
        if (master_reset_signal) begin
            next_pstate = PWR_RUN;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pstate <= PWR_RUN;
        end else begin
            pstate <= next_pstate;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake_cnt <= '0;
        end else if (pstate == PWR_SLEEP && next_pstate == PWR_WAKE_WAIT) begin
            wake_cnt <= WAKE_LOAD;
        end else if (pstate == PWR_WAKE_WAIT && wake_cnt != '0) begin
            wake_cnt <= wake_cnt - CNT_W'(1);
        end else begin
            wake_cnt <= '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wake_done <= 1'b0;
        end else begin
            wake_done <= (pstate != PWR_RUN) && (next_pstate == PWR_RUN) &&
                         !master_reset_signal;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            core_sleeping <= 1'b0;
            core_idling   <= 1'b0;
        end else begin
            core_sleeping <= (next_pstate == PWR_SLEEP) || (next_pstate == PWR_WAKE_WAIT);
            core_idling   <= (next_pstate == PWR_IDLE);
        end
    end

    // retention only when low-power config bit is programmed low
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            retention_active <= 1'b0;
        end else begin
            retention_active <= (next_pstate == PWR_SLEEP) && cause[BIT_RETAIN_EN] &&
                                !low_power_config_bit;
        end
    end

    // slow wake parks the main regulator in standby during sleep
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            regulator_standby <= 1'b0;
        end else begin
            regulator_standby <= (next_pstate == PWR_SLEEP) && !cause[BIT_FAST_WAKE];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            brownout_enable <= 1'b0;
            watchdog_enable <= 1'b0;
        end else begin
            brownout_enable <= bor_effective;
            watchdog_enable <= wdt_effective;
        end
    end

    // read views: cause register, config fields, power state
    always_comb begin
        next_rdata = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                RESET_CAUSE_ADDR: begin
                    // reserved bits already held at zero
                    next_rdata = cause;
                end
                CONFIG_VIEW_ADDR: begin
                    next_rdata = {10'h000, low_power_config_bit, watchdog_config_field,
                                  brownout_config_field, wdt_effective};
                end
                STATE_VIEW_ADDR: begin
                    next_rdata = {11'h000, master_reset_signal, bor_effective,
                                  wdt_effective, pstate};
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule
